// *** core/cdr_pkg.sv ***
// Shared constants of the codec digital routing control block.
// Assumes a 7-bit register address and 9-bit register words from the control port.
package cdr_pkg;

    // Control port geometry
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned REG_W = 9;

    // Register offsets
    localparam logic [6:0] OFF_DAC1_SRC = 7'h0C;
    localparam logic [6:0] OFF_PRI_TX_SRC = 7'h0D;
    localparam logic [6:0] OFF_SEC_TX_SRC = 7'h0E;
    localparam logic [6:0] OFF_RX_DAC_MODE = 7'h0F;
    localparam logic [6:0] OFF_DAC_INVERT = 7'h12;
    localparam logic [6:0] OFF_ADC_CTRL1 = 7'h1D;
    localparam logic [6:0] OFF_SPDIF_TX_SRC = 7'h1E;

    // Field positions
    localparam int unsigned SRC_HI = 8;
    localparam int unsigned SRC_LO = 7;
    localparam int unsigned SPDIF_SRC_HI = 1;
    localparam int unsigned SPDIF_SRC_LO = 0;
    localparam int unsigned RAW_THRU_BIT = 3;
    localparam int unsigned RX_DAC_MODE_BIT = 8;
    localparam int unsigned HPF_BYPASS_BIT = 4;
    localparam int unsigned OSR_HALVE_BIT = 3;
    localparam int unsigned MUTE_BOTH_BIT = 2;
    localparam int unsigned MUTE_RIGHT_BIT = 1;
    localparam int unsigned MUTE_LEFT_BIT = 0;

    // Source codes shared by all source fields
    localparam logic [1:0] SRC_SPDIF_RX = 2'h0;
    localparam logic [1:0] SRC_ADC = 2'h1;
    localparam logic [1:0] SRC_SEC_RX = 2'h2;
    localparam logic [1:0] SRC_PRI_RX = 2'h3;

    // Reset values
    localparam logic [1:0] RST_DAC1_SRC = 2'h3;
    localparam logic [1:0] RST_PRI_SRC = 2'h1;
    localparam logic [1:0] RST_SEC_SRC = 2'h0;
    localparam logic [1:0] RST_SPDIF_SRC = 2'h0;
    localparam logic [7:0] RST_INVERT = 8'hFF;
    localparam logic [4:0] RST_ADC_CTRL = 5'h00;

    // Master clock ratio codes
    localparam logic [2:0] RATIO_128FS = 3'h0;
    localparam logic [2:0] RATIO_192FS = 3'h1;
    localparam logic [2:0] RATIO_256FS = 3'h2;

    // Oversampling rate codes
    localparam logic [1:0] OSR_128 = 2'h0;
    localparam logic [1:0] OSR_64 = 2'h1;
    localparam logic [1:0] OSR_32 = 2'h2;

    // DAC rate reference codes
    localparam logic [1:0] RATE_PRI = 2'h0;
    localparam logic [1:0] RATE_SEC = 2'h1;
    localparam logic [1:0] RATE_SPDIF = 2'h2;

endpackage : cdr_pkg

// *** core/cdr_pair_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module cdr_pair_buf #(
    parameter int unsigned W = 48
) (
    input logic i_sys_clk,
    input logic i_sys_rst,
    input logic i_in_valid,
    output logic o_in_ready,
    input logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input logic i_out_ready,
    output logic [W-1:0] o_out_data
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } cdr_buf_state_t;

    cdr_buf_state_t s;
    cdr_buf_state_t next_s;
    logic push;
    logic pop;

    // Handshakes straight from the count
    assign o_in_ready = (s.cnt != 2'h2);
    assign o_out_valid = (s.cnt != 2'h0);
    assign o_out_data = s.mem[s.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer and count update; simultaneous push and pop keeps the count
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = i_in_data;
            next_s.wp = ~s.wp;
        end
        if (pop) begin
            next_s.rp = ~s.rp;
        end
        next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    property p_buf_full_stalls;
        (s.cnt == 2'h2) && !i_out_ready |=> !o_in_ready && o_out_data == $past(o_out_data);
    endproperty
    a_buf_full_stalls: assert property (p_buf_full_stalls) else $error("buffer lost a word");

endmodule : cdr_pair_buf

// *** core/cdr_routing.sv ***
// Digital routing and control of a multichannel codec: source muxes, phase, ADC control.
// Assumes all sample inputs come from logic on i_sys_clk, one frame per i_frame_valid beat;
// the S/PDIF input mux bit comes from a pin and is synchronised here.
`timescale 1ns/1ns
module cdr_routing #(
    parameter int unsigned W = 24
) (
    input logic i_sys_clk,
    input logic i_sys_rst,
    input logic i_reg_wr,
    input logic i_reg_rd,
    input logic [cdr_pkg::ADDR_W-1:0] i_reg_addr,
    input logic [cdr_pkg::REG_W-1:0] i_reg_wdata,
    output logic [cdr_pkg::REG_W-1:0] o_reg_rdata,
    input logic [7:0] i_din_route,
    input logic [2:0] i_mclk_ratio,
    input logic i_frame_valid,
    output logic o_frame_ready,
    input logic [3:0][2*W-1:0] i_dac_serial_inputs,
    input logic [2*W-1:0] i_spdif_rx_data,
    input logic [2*W-1:0] i_sec_rx_data,
    input logic [2*W-1:0] i_adc_data,
    output logic [3:0][2*W-1:0] o_dac_data,
    output logic [2*W-1:0] o_pri_tx_data,
    output logic [2*W-1:0] o_sec_tx_data,
    output logic o_frame_stb,
    output logic o_spdif_tx_valid,
    input logic i_spdif_tx_ready,
    output logic [2*W-1:0] o_spdif_tx_data,
    input logic i_spdif_tx_serial,
    input logic i_spdif_in_mux,
    output logic o_spdif_output_pin,
    output logic [2:0] o_dac_pwrdn,
    output logic [1:0] o_dac_rate_src,
    output logic o_adc_highpass_bypass,
    output logic [1:0] o_adc_osr
);
    import cdr_pkg::*;

    typedef struct packed {
        logic [1:0] dac1_src;
        logic [1:0] pri_src;
        logic [1:0] sec_src;
        logic [1:0] spdif_src;
        logic raw_thru;
        logic rx2dac;
        logic [7:0] invert;
        logic [4:0] adc_ctrl;
        logic [REG_W-1:0] rdata;
        logic pin_s1;
        logic pin_s2;
        logic spdif_pin;
        logic [1:0] osr;
        logic frame_stb;
        logic [3:0][2*W-1:0] dac;
        logic [2*W-1:0] pri_tx;
        logic [2*W-1:0] sec_tx;
    } cdr_state_t;

    cdr_state_t s;
    cdr_state_t next_s;
    logic take;
    logic dac_off;
    logic [3:0][2*W-1:0] routed;
    logic [2*W-1:0] adc_muted;
    logic [2*W-1:0] spdif_tx_in;

    // Two's complement negate; the most negative code saturates instead of wrapping
    function automatic logic [W-1:0] neg_sat(input logic [W-1:0] x);
        logic [W-1:0] r;
        r = ~x + {{(W-1){1'b0}}, 1'b1};
        if (x == {1'b1, {(W-1){1'b0}}}) begin
            r = {1'b0, {(W-1){1'b1}}};
        end
        return r;
    endfunction : neg_sat

    // Four-way source mux; reserved codes give silence rather than stale data
    function automatic logic [2*W-1:0] pick(input logic [1:0] code,
                                            input logic [3:0] ok,
                                            input logic [2*W-1:0] s0,
                                            input logic [2*W-1:0] s1,
                                            input logic [2*W-1:0] s2,
                                            input logic [2*W-1:0] s3);
        logic [2*W-1:0] r;
        r = '0;
        if (!ok[code]) begin
            r = '0;
        end else if (code == SRC_SPDIF_RX) begin
            r = s0;
        end else if (code == SRC_ADC) begin
            r = s1;
        end else if (code == SRC_SEC_RX) begin
            r = s2;
        end else begin
            r = s3;
        end
        return r;
    endfunction : pick

    // Base rate from master ratio, one step down when halved
    function automatic logic [1:0] osr_code(input logic [2:0] ratio, input logic halve);
        logic [1:0] base;
        base = OSR_128;
        if (ratio == RATIO_128FS || ratio == RATIO_192FS) begin
            base = OSR_64;
        end
        return halve ? base + 2'h1 : base;
    endfunction : osr_code

    // Primary receiver crossbar: two select bits per DAC pick an input stream
    always_comb begin
        for (int d = 0; d < 4; d++) begin
            routed[d] = i_dac_serial_inputs[i_din_route[2*d +: 2]];
        end
    end

    // ADC mutes; the both-channel bit overrides the single ones
    assign adc_muted[W-1:0] = (s.adc_ctrl[MUTE_LEFT_BIT] || s.adc_ctrl[MUTE_BOTH_BIT]) ?
                              '0 : i_adc_data[W-1:0];
    assign adc_muted[2*W-1:W] = (s.adc_ctrl[MUTE_RIGHT_BIT] || s.adc_ctrl[MUTE_BOTH_BIT]) ?
                                '0 : i_adc_data[2*W-1:W];

    // DACs two to four shut down only in pure S/PDIF mode
    assign dac_off = (s.dac1_src == SRC_SPDIF_RX) && !s.rx2dac;
    assign o_dac_pwrdn = {3{dac_off}};
    assign o_dac_rate_src = dac_off ? RATE_SPDIF :
                            (s.dac1_src == SRC_SEC_RX) ? RATE_SEC : RATE_PRI;

    // A frame moves only when the S/PDIF buffer has room, so no path runs ahead
    assign take = i_frame_valid && o_frame_ready;
    assign spdif_tx_in = pick(s.spdif_src, 4'hF, i_spdif_rx_data, adc_muted,
                              i_sec_rx_data, routed[0]);

    // Next state: control port, pin sync, frame routing
    always_comb begin
        next_s = s;
        next_s.pin_s1 = i_spdif_in_mux;
        next_s.pin_s2 = s.pin_s1;
        next_s.spdif_pin = s.raw_thru ? s.pin_s2 : i_spdif_tx_serial;
        next_s.osr = osr_code(i_mclk_ratio, s.adc_ctrl[OSR_HALVE_BIT]);
        next_s.frame_stb = take;
        if (i_reg_wr) begin
            if (i_reg_addr == OFF_DAC1_SRC) begin
                next_s.dac1_src = i_reg_wdata[SRC_HI:SRC_LO];
            end else if (i_reg_addr == OFF_PRI_TX_SRC) begin
                next_s.pri_src = i_reg_wdata[SRC_HI:SRC_LO];
            end else if (i_reg_addr == OFF_SEC_TX_SRC) begin
                next_s.sec_src = i_reg_wdata[SRC_HI:SRC_LO];
            end else if (i_reg_addr == OFF_RX_DAC_MODE) begin
                next_s.rx2dac = i_reg_wdata[RX_DAC_MODE_BIT];
            end else if (i_reg_addr == OFF_DAC_INVERT) begin
                next_s.invert = i_reg_wdata[7:0];
            end else if (i_reg_addr == OFF_ADC_CTRL1) begin
                next_s.adc_ctrl = i_reg_wdata[4:0];
            end else if (i_reg_addr == OFF_SPDIF_TX_SRC) begin
                next_s.spdif_src = i_reg_wdata[SPDIF_SRC_HI:SPDIF_SRC_LO];
                next_s.raw_thru = i_reg_wdata[RAW_THRU_BIT];
            end
        end
        // Readback of stored fields, unmapped addresses read zero
        if (i_reg_rd) begin
            next_s.rdata = '0;
            if (i_reg_addr == OFF_DAC1_SRC) begin
                next_s.rdata[SRC_HI:SRC_LO] = s.dac1_src;
            end else if (i_reg_addr == OFF_PRI_TX_SRC) begin
                next_s.rdata[SRC_HI:SRC_LO] = s.pri_src;
            end else if (i_reg_addr == OFF_SEC_TX_SRC) begin
                next_s.rdata[SRC_HI:SRC_LO] = s.sec_src;
            end else if (i_reg_addr == OFF_RX_DAC_MODE) begin
                next_s.rdata[RX_DAC_MODE_BIT] = s.rx2dac;
            end else if (i_reg_addr == OFF_DAC_INVERT) begin
                next_s.rdata[7:0] = s.invert;
            end else if (i_reg_addr == OFF_ADC_CTRL1) begin
                next_s.rdata[4:0] = s.adc_ctrl;
            end else if (i_reg_addr == OFF_SPDIF_TX_SRC) begin
                next_s.rdata[SPDIF_SRC_HI:SPDIF_SRC_LO] = s.spdif_src;
                next_s.rdata[RAW_THRU_BIT] = s.raw_thru;
            end
        end
        if (take) begin
            next_s.dac[0] = pick(s.dac1_src, 4'hD, i_spdif_rx_data, '0,
                                 i_sec_rx_data, routed[0]);
            for (int d = 1; d < 4; d++) begin
                next_s.dac[d] = dac_off ? '0 : routed[d];
            end
            // Phase: even bit is left (low half), odd bit is right
            for (int d = 0; d < 4; d++) begin
                if (s.invert[2*d]) begin
                    next_s.dac[d][W-1:0] = neg_sat(next_s.dac[d][W-1:0]);
                end
                if (s.invert[2*d+1]) begin
                    next_s.dac[d][2*W-1:W] = neg_sat(next_s.dac[d][2*W-1:W]);
                end
            end
            next_s.pri_tx = pick(s.pri_src, 4'h7, i_spdif_rx_data, adc_muted,
                                 i_sec_rx_data, '0);
            next_s.sec_tx = pick(s.sec_src, 4'hB, i_spdif_rx_data, adc_muted,
                                 '0, routed[0]);
        end
    end

    // Reset loads documented defaults; everything else clears
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s <= '0;
            s.dac1_src <= RST_DAC1_SRC;
            s.pri_src <= RST_PRI_SRC;
            s.sec_src <= RST_SEC_SRC;
            s.spdif_src <= RST_SPDIF_SRC;
            s.invert <= RST_INVERT;
            s.adc_ctrl <= RST_ADC_CTRL;
        end else begin
            s <= next_s;
        end
    end

    // S/PDIF transmit samples queue here so a transmitter stall drops nothing
    cdr_pair_buf #(
        .W(2*W)
    ) u_spdif_buf (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_frame_valid),
        .o_in_ready(o_frame_ready),
        .i_in_data(spdif_tx_in),
        .o_out_valid(o_spdif_tx_valid),
        .i_out_ready(i_spdif_tx_ready),
        .o_out_data(o_spdif_tx_data)
    );

    // Registered outputs
    assign o_reg_rdata = s.rdata;
    assign o_dac_data = s.dac;
    assign o_pri_tx_data = s.pri_tx;
    assign o_sec_tx_data = s.sec_tx;
    assign o_frame_stb = s.frame_stb;
    assign o_spdif_output_pin = s.spdif_pin;
    assign o_adc_highpass_bypass = s.adc_ctrl[HPF_BYPASS_BIT];
    assign o_adc_osr = s.osr;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    property p_inv_reset;
        $fell(i_sys_rst) |-> s.invert == RST_INVERT && s.dac1_src == RST_DAC1_SRC;
    endproperty
    a_inv_reset: assert property (p_inv_reset) else $error("bad reset defaults");

    property p_phase_dac2;
        take && !dac_off && s.invert[2] |=>
            o_dac_data[1][W-1:0] == neg_sat($past(routed[1][W-1:0]));
    endproperty
    a_phase_dac2: assert property (p_phase_dac2) else $error("DAC2L not inverted");

    property p_hpf_bypass;
        i_reg_wr && i_reg_addr == OFF_ADC_CTRL1 ##1 1'b1 |->
            o_adc_highpass_bypass == $past(i_reg_wdata[HPF_BYPASS_BIT]);
    endproperty
    a_hpf_bypass: assert property (p_hpf_bypass) else $error("bypass bit ignored");

    property p_osr_low_ratio;
        i_mclk_ratio == RATIO_192FS && !s.adc_ctrl[OSR_HALVE_BIT] |=> o_adc_osr == OSR_64;
    endproperty
    a_osr_low_ratio: assert property (p_osr_low_ratio) else $error("wrong base rate");

    property p_osr_halve;
        i_mclk_ratio == RATIO_128FS && s.adc_ctrl[OSR_HALVE_BIT] |=> o_adc_osr == OSR_32;
    endproperty
    a_osr_halve: assert property (p_osr_halve) else $error("halving failed");

    property p_adc_mute_both;
        take && s.pri_src == SRC_ADC && s.adc_ctrl[MUTE_BOTH_BIT] |=> o_pri_tx_data == '0;
    endproperty
    a_adc_mute_both: assert property (p_adc_mute_both) else $error("ADC not muted");

    property p_dac_off;
        take && dac_off |-> o_dac_pwrdn == 3'h7 ##1 o_dac_data[3] == '0 && o_frame_stb;
    endproperty
    a_dac_off: assert property (p_dac_off) else $error("DACs 2-4 still live");

    property p_sec_from_dac1;
        take && s.sec_src == SRC_PRI_RX |=> o_sec_tx_data == $past(routed[0]);
    endproperty
    a_sec_from_dac1: assert property (p_sec_from_dac1) else $error("bad secondary source");

    property p_spdif_thru;
        take && s.spdif_src == SRC_SPDIF_RX && !o_spdif_tx_valid |=>
            o_spdif_tx_valid && o_spdif_tx_data == $past(i_spdif_rx_data);
    endproperty
    a_spdif_thru: assert property (p_spdif_thru) else $error("thru data wrong");

    property p_raw_thru;
        s.raw_thru |=> o_spdif_output_pin == $past(s.pin_s2);
    endproperty
    a_raw_thru: assert property (p_raw_thru) else $error("pin not on input mux");

    c_raw_thru: cover property (s.raw_thru ##1 o_spdif_output_pin);
    c_buf_full: cover property (i_frame_valid && !o_frame_ready);
    c_dac1_sec: cover property (take && s.dac1_src == SRC_SEC_RX);
    c_rx2dac: cover property (take && s.dac1_src == SRC_SPDIF_RX && s.rx2dac);

endmodule : cdr_routing

// *** verification/cdr_tx_sink.sv ***
// Stand-in for the S/PDIF transmitter: pops buffered words, makes a serial bit.
// Assumes the routing block's clock; all changes land just after the rising edge.
`timescale 1ns/1ns
module cdr_tx_sink #(
    parameter int unsigned W = 24
) (
    input logic i_sys_clk,
    input logic i_stall,
    input logic i_valid,
    input logic [2*W-1:0] i_data,
    output logic o_ready,
    output logic o_serial,
    output logic [7:0] o_pops,
    output logic [2*W-1:0] o_last
);
    logic [2:0] pat = 3'h1;
    initial o_ready = 1'b0;
    initial o_serial = 1'b0;
    initial o_pops = 8'h00;
    initial o_last = '0;
    // Serial bit is a short pseudo-random run, so a stuck pin cannot pass
    always @(posedge i_sys_clk) begin
        o_ready <= !i_stall;
        pat <= {pat[1:0], pat[2] ^ pat[1]};
        o_serial <= pat[2];
        if (i_valid && o_ready) begin
            o_pops <= o_pops + 8'h01;
            o_last <= i_data;
        end
    end
endmodule : cdr_tx_sink

// *** verification/cdr_routing_bench.sv ***
// Self-checking bench: register port, source muxes, S/PDIF buffer and pin path.
// Assumes the routing package and the transmitter stand-in are compiled first.
`timescale 1ns/1ns
module cdr_routing_bench;
    import cdr_pkg::*;
    localparam int unsigned W = 24;
    typedef logic [2*W-1:0] cdr_word_t;
    typedef struct {
        logic [1:0] d1, p, s, t;
        logic m;
        logic [2:0] a;
        logic [7:0] rt;
        int e1, ep, es, et, rate;
    } cdr_row_t;
    logic clk, rst, reg_wr, reg_rd, fv, fr, stb, txv, txr, ser, ser_s, mux, pin, stall, hpb, off;
    logic [6:0] reg_addr;
    logic [8:0] reg_wdata, reg_rdata;
    logic [7:0] route, pops;
    logic [2:0] ratio, pwr;
    logic [1:0] rsrc, osr;
    logic [3:0][2*W-1:0] din, dac;
    cdr_word_t srx, sec, adc, ptx, stx, txd, last, d1s;
    int errors, checks, n;
    cdr_row_t w;
    // Sources, mode, ADC mutes, crossbar; source 4 is a zero word, rate 3 unchecked
    cdr_row_t rows [5] = '{
        '{2'h3, 2'h1, 2'h0, 2'h0, 1'b0, 3'h2, 8'h1b, 3, 1, 0, 0, 0},
        '{2'h0, 2'h0, 2'h1, 2'h1, 1'b0, 3'h1, 8'he4, 0, 0, 1, 1, 2},
        '{2'h2, 2'h2, 2'h3, 2'h2, 1'b0, 3'h0, 8'h4e, 2, 2, 3, 2, 1},
        '{2'h1, 2'h3, 2'h2, 2'h3, 1'b0, 3'h4, 8'hb1, 4, 4, 4, 3, 3},
        '{2'h0, 2'h1, 2'h3, 2'h3, 1'b1, 3'h4, 8'he4, 0, 1, 3, 3, 0}
    };
    cdr_routing #(.W(W)) i_cdr_routing (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .i_din_route(route), .i_mclk_ratio(ratio), .i_frame_valid(fv), .o_frame_ready(fr),
        .i_dac_serial_inputs(din), .i_spdif_rx_data(srx), .i_sec_rx_data(sec),
        .i_adc_data(adc), .o_dac_data(dac), .o_pri_tx_data(ptx), .o_sec_tx_data(stx),
        .o_frame_stb(stb), .o_spdif_tx_valid(txv), .i_spdif_tx_ready(txr),
        .o_spdif_tx_data(txd), .i_spdif_tx_serial(ser), .i_spdif_in_mux(mux),
        .o_spdif_output_pin(pin), .o_dac_pwrdn(pwr), .o_dac_rate_src(rsrc),
        .o_adc_highpass_bypass(hpb), .o_adc_osr(osr)
    );
    cdr_tx_sink #(.W(W)) i_cdr_tx_sink (
        .i_sys_clk(clk), .i_stall(stall), .i_valid(txv), .i_data(txd), .o_ready(txr),
        .o_serial(ser), .o_pops(pops), .o_last(last)
    );
    // Clock, and the serial level the design saw at each edge
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) ser_s <= ser;

    task automatic summarize();
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input cdr_word_t seen, input cdr_word_t exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr_reg
    // Read data stands in the cycle after the read edge
    task automatic rd_reg(input logic [6:0] a, input logic [8:0] exp);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
    endtask : rd_reg
    // Valid held until ready; a hang ends the run as a mismatch
    task automatic send_frame();
        int i;
        @(negedge clk);
        fv = 1'b1;
        for (i = 0; i < 40 && fr !== 1'b1; i++) @(negedge clk);
        if (i == 40) begin
            errors++;
            summarize();
        end
        @(negedge clk);
        fv = 1'b0;
    endtask : send_frame
    task automatic wait_pops(input logic [7:0] target);
        int i;
        for (i = 0; i < 40 && pops !== target; i++) @(negedge clk);
        if (i == 40) begin
            errors++;
            summarize();
        end
    endtask : wait_pops
    // Expected word of a source code; ADC mutes only touch the ADC word
    function automatic cdr_word_t pick(input int sel, input logic [2:0] a);
        cdr_word_t aw;
        aw = adc;
        if (a[0] || a[2]) aw[W-1:0] = '0;
        if (a[1] || a[2]) aw[2*W-1:W] = '0;
        case (sel)
            0: pick = srx;
            1: pick = aw;
            2: pick = sec;
            3: pick = d1s;
            default: pick = '0;
        endcase
    endfunction : pick

    initial begin
        {rst, reg_wr, reg_rd, fv, mux, stall} = 6'h20;
        reg_addr = 7'h00;
        reg_wdata = 9'h000;
        route = 8'he4;
        ratio = 3'h2;
        din = {48'h0000_4200_0041, 48'h0000_3200_0031, 48'h0000_2200_0021, 48'h0000_1200_0011};
        srx = 48'h0000_5200_0051;
        sec = 48'h0000_6200_0061;
        adc = 48'h0000_7200_0071;
        errors = 0;
        checks = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        wr_reg(OFF_DAC_INVERT, 9'h000);
        // Ordinary routing cases, one frame each
        foreach (rows[r]) begin
            w = rows[r];
            wr_reg(OFF_DAC1_SRC, {w.d1, 7'h00});
            wr_reg(OFF_PRI_TX_SRC, {w.p, 7'h00});
            wr_reg(OFF_SEC_TX_SRC, {w.s, 7'h00});
            wr_reg(OFF_RX_DAC_MODE, {w.m, 8'h00});
            wr_reg(OFF_SPDIF_TX_SRC, {7'h00, w.t});
            wr_reg(OFF_ADC_CTRL1, {6'h00, w.a});
            route = w.rt;
            rd_reg(OFF_DAC1_SRC, {w.d1, 7'h00});
            n = pops;
            send_frame();
            chk(stb, 1'b1);
            d1s = din[w.rt[1:0]];
            off = (w.d1 == 2'h0) && !w.m;
            chk(dac[0], pick(w.e1, w.a));
            for (int d = 1; d < 4; d++) chk(dac[d], din[w.rt[2*d+:2]] & {2*W{!off}});
            chk(ptx, pick(w.ep, w.a));
            chk(stx, pick(w.es, w.a));
            chk(pwr, {3{off}});
            if (w.rate != 3) chk(rsrc, w.rate);
            wait_pops(8'(n + 1));
            chk(last, pick(w.et, w.a));
        end
        // Phase inversion, with the most negative sample saturating
        wr_reg(OFF_DAC1_SRC, 9'h180);
        wr_reg(OFF_DAC_INVERT, 9'h085);
        din[0] = 48'h0000_1280_0000;
        send_frame();
        chk(dac[0], 48'h0000_127f_ffff);
        chk(dac[1], 48'h0000_22ff_ffdf);
        chk(dac[2], din[2]);
        chk(dac[3], 48'hffff_be00_0041);
        // High-pass bypass, then every master ratio with and without halving
        wr_reg(OFF_ADC_CTRL1, 9'h010);
        chk(hpb, 1'b1);
        rd_reg(OFF_ADC_CTRL1, 9'h010);
        for (int h = 0; h < 2; h++) begin
            wr_reg(OFF_ADC_CTRL1, 9'(h * 8));
            for (int k = 0; k < 6; k++) begin
                @(negedge clk);
                ratio = 3'(k);
                @(negedge clk);
                chk(osr, (k < 2 ? 1 : 0) + h);
            end
        end
        // Stalled transmitter: two words fill the buffer, a third frame waits
        stall = 1'b1;
        repeat (2) @(negedge clk);
        n = pops;
        send_frame();
        send_frame();
        @(negedge clk);
        fv = 1'b1;
        repeat (3) begin
            @(negedge clk);
            chk(fr, 1'b0);
            chk(stb, 1'b0);
            chk(txv, 1'b1);
        end
        stall = 1'b0;
        send_frame();
        wait_pops(8'(n + 3));
        @(negedge clk);
        chk(txv, 1'b0);
        // Pin follows the transmitter, then the raw input mux bit
        wr_reg(OFF_SPDIF_TX_SRC, 9'h000);
        repeat (6) begin
            @(negedge clk);
            chk(pin, ser_s);
        end
        wr_reg(OFF_SPDIF_TX_SRC, 9'h008);
        for (int b = 0; b < 2; b++) begin
            mux = 1'(1 - b);
            repeat (4) @(negedge clk);
            chk(pin, 1 - b);
        end
        // Unmapped place, then a second reset in mid-run
        wr_reg(7'h10, 9'h1ff);
        rd_reg(7'h10, 9'h000);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rd_reg(OFF_DAC1_SRC, 9'h180);
        rd_reg(OFF_PRI_TX_SRC, 9'h080);
        rd_reg(OFF_SEC_TX_SRC, 9'h000);
        rd_reg(OFF_RX_DAC_MODE, 9'h000);
        rd_reg(OFF_DAC_INVERT, 9'h0ff);
        rd_reg(OFF_ADC_CTRL1, 9'h000);
        rd_reg(OFF_SPDIF_TX_SRC, 9'h000);
        chk(fr, 1'b1);
        chk(osr, 2'h0);
        chk(hpb, 1'b0);
        chk(pwr, 3'h0);
        chk(rsrc, 2'h0);
        summarize();
    end
endmodule : cdr_routing_bench
